/* common/dvg_regs.vh */
// Constants for the DSP to VME glue logic: segments, status codes, states.
`ifndef DVG_REGS_VH
`define DVG_REGS_VH
// Address nibble {top bit, segment bits}; the top bit is always one.
`define DVG_SEG_EPROM 4'hc
`define DVG_SEG_VME 4'hd
`define DVG_SEG_REGS 4'hf
// Status codes for reads (10xx) and writes (1101, 1110).
`define DVG_STAT_RD_MASK 4'hc
`define DVG_STAT_RD_VAL 4'h8
`define DVG_STAT_WR_A 4'hd
`define DVG_STAT_WR_B 4'he
// Power-up reset sequencer states.
`define DVG_RS_IDLE 3'h0
`define DVG_RS_IRQ 3'h1
`define DVG_RS_PL0A 3'h2
`define DVG_RS_PL0B 3'h3
`define DVG_RS_DROP 3'h4
`define DVG_RS_DONE 3'h5
// Bus control sequencer states.
`define DVG_BC_IDLE 3'h0
`define DVG_BC_MWAIT 3'h1
`define DVG_BC_MRDY 3'h2
`define DVG_BC_SOFF 3'h3
`define DVG_BC_SMOE 3'h4
`define DVG_BC_SSOE 3'h5
`define DVG_BC_SGNT 3'h6
// Slave sequencer states.
`define DVG_SL_IDLE 2'h0
`define DVG_SL_STRB 2'h1
`define DVG_SL_ACK 2'h2
`define DVG_SL_WAIT 2'h3
// Function code for supervisory data.
`define DVG_FC_SUPDATA 3'h5
// Transfer size code for a 32-bit longword.
`define DVG_SIZE_LONG 2'h0
`endif

/* rtl/dvg_reset_seq.v */
// Power-up global reset handshake sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "dvg_regs.vh"
module dvg_reset_seq (
    input wire i_clk,
    input wire i_resetn,
    input wire i_power_up,
    input wire i_board_reset_n,
    output wire o_interrupt_reset_n,
    output wire o_priority_level_zero_line_n
);
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    always @* begin
        state_nxt = state_r;
        if (!i_power_up) begin
            state_nxt = `DVG_RS_IDLE; // [RQ23]
        end else begin
            case (state_r)
                `DVG_RS_IDLE: state_nxt = `DVG_RS_IRQ; // [RQ1]
                `DVG_RS_IRQ: begin
                    if (!i_board_reset_n) begin
                        state_nxt = `DVG_RS_PL0A; // [RQ2]
                    end
                end
                `DVG_RS_PL0A: state_nxt = `DVG_RS_PL0B; // [RQ3]
                `DVG_RS_PL0B: state_nxt = `DVG_RS_DROP;
                `DVG_RS_DROP: state_nxt = `DVG_RS_DONE; // [RQ4]
                `DVG_RS_DONE: state_nxt = `DVG_RS_DONE;
                default: state_nxt = `DVG_RS_IDLE;
            endcase
        end
    end
    // The sequencer must survive the board reset it provokes, so it uses
    // only the power-up reset and not the board reset.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= `DVG_RS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end
    assign o_interrupt_reset_n = (state_r == `DVG_RS_IDLE) ||
        (state_r == `DVG_RS_DONE); // [RQ1] [RQ4]
    assign o_priority_level_zero_line_n = !((state_r == `DVG_RS_PL0A) ||
        (state_r == `DVG_RS_PL0B)); // [RQ3]
endmodule
`default_nettype wire

/* rtl/dvg_decoder.v */
// Strobe-1 address and status decoder with registered active-low selects.
`timescale 1ns/1ps
`default_nettype none
`include "dvg_regs.vh"
module dvg_decoder (
    input wire i_clk,
    input wire i_resetn,
    input wire i_board_reset_n,
    input wire [3:0] i_status,
    input wire [2:0] i_segment_address_bits,
    input wire i_dsp_strobe_one_n,
    output reg o_master_rd_n,
    output reg o_master_wr_n,
    output reg o_reg_rd_n,
    output reg o_reg_wr_n,
    output reg o_eprom_rd_n
);
    wire [3:0] addr = {1'b1, i_segment_address_bits}; // [RQ10]
    wire qual = i_board_reset_n && !i_dsp_strobe_one_n; // [RQ8] [RQ22]
    wire is_rd = (i_status & `DVG_STAT_RD_MASK) == `DVG_STAT_RD_VAL; // [RQ9]
    wire is_wr = (i_status == `DVG_STAT_WR_A) ||
        (i_status == `DVG_STAT_WR_B); // [RQ22]
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_master_rd_n <= 1'b1;
            o_master_wr_n <= 1'b1;
            o_reg_rd_n <= 1'b1;
            o_reg_wr_n <= 1'b1;
            o_eprom_rd_n <= 1'b1;
        end else begin
            o_master_rd_n <= !(qual && is_rd &&
                addr == `DVG_SEG_VME); // [RQ7] [RQ11]
            o_master_wr_n <= !(qual && is_wr && addr == `DVG_SEG_VME);
            o_reg_rd_n <= !(qual && is_rd &&
                addr == `DVG_SEG_REGS); // [RQ12]
            o_reg_wr_n <= !(qual && is_wr && addr == `DVG_SEG_REGS);
            o_eprom_rd_n <= !(qual && is_rd && addr == `DVG_SEG_EPROM);
        end
    end
endmodule
`default_nettype wire

/* rtl/dvg_glue.v */
// Top of the DSP to VME glue: reset sequencer, decoder, bus control.
// What this block does
// [RQ1] Power-up high drives interrupt-reset low.
// [RQ2] Wait for bus-controller reset answer low.
// [RQ3] Priority-level-zero low for two clocks.
// [RQ4] Release priority line, then interrupt-reset, idle.
// [RQ5] Bus controller drives system reset 200 ms.
// [RQ6] Bus-controller reset resets all board logic except the reset sequencer; o_shared_sram_read_write and o_function_code keep their values.
// [RQ7] VME window decoded at base 0D000 0000h.
// [RQ8] Decode every strobe-1 cycle on clock.
// [RQ9] Read or write from status lines only.
// [RQ10] Eight segments, top address bit fixed one.
// [RQ11] Five active-low decoder selects.
// [RQ12] Register selects cover both chip register sets.
// [RQ13] Bus control drives five outputs.
// [RQ14] Bus control runs on the 20 MHz clock.
// [RQ15] Decoded access starts master cycle; enable master outputs.
// [RQ16] Acks or bus error end cycle; ready.
// [RQ17] Ready is external only, high between accesses.
// [RQ18] Slave request: bus off, master off, slave on, grant.
// [RQ19] Slave cycle ends when request drops.
// [RQ20] Master cycles drive supervisory-data function code.
// [RQ21] Granted longword slave: SRAM strobe, then acks.
// [RQ22] Status 10xx reads, 1101/1110 writes, qualified.
// [RQ23] Power-up low restarts the reset sequencer.
// [RQ24] Longword transfers only, no byte swapping.
// [RQ25] Board reset holds bus control idle and decoder selects inactive.
`timescale 1ns/1ps
`default_nettype none
`include "dvg_regs.vh"
module dvg_glue (
    input wire i_clk,
    input wire i_resetn,
    input wire i_power_up,
    input wire i_board_reset_n,
    input wire [3:0] i_status,
    input wire [2:0] i_segment_address_bits,
    input wire i_dsp_strobe_one_n,
    input wire i_local_bus_request_n,
    input wire i_data_size_ack_low_n,
    input wire i_data_size_ack_high_n,
    input wire i_local_bus_error_n,
    input wire [1:0] i_slave_size,
    input wire i_slave_rd,
    input wire i_slave_strobe_n,
    output wire o_interrupt_reset_n,
    output wire o_priority_level_zero_line_n,
    output wire o_master_rd_n,
    output wire o_master_wr_n,
    output wire o_reg_rd_n,
    output wire o_reg_wr_n,
    output wire o_eprom_rd_n,
    output reg o_global_bus_enable_n,
    output reg o_master_oe_n,
    output reg o_slave_oe_n,
    output reg o_local_bus_grant_n,
    output reg o_dsp_ready_out_n,
    output reg [2:0] o_function_code,
    output reg o_shared_sram_strobe_n,
    output reg o_shared_sram_read_write,
    output reg o_slave_ack_low_n,
    output reg o_slave_ack_high_n
);
    reg [2:0] bc_r;
    reg [2:0] bc_nxt;
    reg [1:0] sl_r;
    reg [1:0] sl_nxt;
    wire mreq;
    wire rst_all;

    dvg_reset_seq u_reset (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_power_up(i_power_up),
        .i_board_reset_n(i_board_reset_n),
        .o_interrupt_reset_n(o_interrupt_reset_n),
        .o_priority_level_zero_line_n(o_priority_level_zero_line_n)
    );

    dvg_decoder u_dec (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_board_reset_n(i_board_reset_n),
        .i_status(i_status),
        .i_segment_address_bits(i_segment_address_bits),
        .i_dsp_strobe_one_n(i_dsp_strobe_one_n),
        .o_master_rd_n(o_master_rd_n),
        .o_master_wr_n(o_master_wr_n),
        .o_reg_rd_n(o_reg_rd_n),
        .o_reg_wr_n(o_reg_wr_n),
        .o_eprom_rd_n(o_eprom_rd_n)
    );

    // EPROM reads run at full speed and never enter a master cycle.
    assign mreq = !o_master_rd_n || !o_master_wr_n ||
        !o_reg_rd_n || !o_reg_wr_n; // [RQ15]
    // The board reset comes from the bus controller itself.
    assign rst_all = !i_board_reset_n; // [RQ6] [RQ25]

    always @* begin
        bc_nxt = bc_r;
        case (bc_r)
            `DVG_BC_IDLE: begin
                if (!i_local_bus_request_n) begin
                    bc_nxt = `DVG_BC_SOFF; // [RQ18]
                end else if (mreq) begin
                    bc_nxt = `DVG_BC_MWAIT; // [RQ15]
                end
            end
            `DVG_BC_MWAIT: begin
                if ((!i_data_size_ack_low_n && !i_data_size_ack_high_n) ||
                    !i_local_bus_error_n) begin
                    bc_nxt = `DVG_BC_MRDY; // [RQ16]
                end
            end
            `DVG_BC_MRDY: bc_nxt = `DVG_BC_IDLE;
            `DVG_BC_SOFF: bc_nxt = `DVG_BC_SMOE;
            `DVG_BC_SMOE: bc_nxt = `DVG_BC_SSOE;
            `DVG_BC_SSOE: bc_nxt = `DVG_BC_SGNT;
            `DVG_BC_SGNT: begin
                if (i_local_bus_request_n) begin
                    bc_nxt = `DVG_BC_IDLE; // [RQ19]
                end
            end
            default: bc_nxt = `DVG_BC_IDLE;
        endcase
    end

    // Slave SRAM access; only longwords are served, others never acked.
    always @* begin
        sl_nxt = sl_r;
        case (sl_r)
            `DVG_SL_IDLE: begin
                if (!o_local_bus_grant_n && !i_slave_strobe_n &&
                    i_slave_size == `DVG_SIZE_LONG) begin
                    sl_nxt = `DVG_SL_STRB; // [RQ21] [RQ24]
                end
            end
            `DVG_SL_STRB: sl_nxt = `DVG_SL_ACK;
            `DVG_SL_ACK: sl_nxt = `DVG_SL_WAIT;
            `DVG_SL_WAIT: begin
                if (i_slave_strobe_n) begin
                    sl_nxt = `DVG_SL_IDLE;
                end
            end
            default: sl_nxt = `DVG_SL_IDLE;
        endcase
        if (o_local_bus_grant_n) begin
            sl_nxt = `DVG_SL_IDLE;
        end
    end

    // Runs at the phase-three clock rate; cycles are paced by handshakes.
    always @(posedge i_clk or negedge i_resetn) begin // [RQ14]
        if (!i_resetn) begin
            bc_r <= `DVG_BC_IDLE;
            sl_r <= `DVG_SL_IDLE;
            o_global_bus_enable_n <= 1'b0;
            o_master_oe_n <= 1'b0;
            o_slave_oe_n <= 1'b1;
            o_local_bus_grant_n <= 1'b1;
            o_dsp_ready_out_n <= 1'b1;
            o_function_code <= `DVG_FC_SUPDATA;
            o_shared_sram_strobe_n <= 1'b1;
            o_shared_sram_read_write <= 1'b1;
            o_slave_ack_low_n <= 1'b1;
            o_slave_ack_high_n <= 1'b1;
        end else if (rst_all) begin
            bc_r <= `DVG_BC_IDLE; // [RQ25]
            sl_r <= `DVG_SL_IDLE;
            o_global_bus_enable_n <= 1'b0;
            o_master_oe_n <= 1'b0;
            o_slave_oe_n <= 1'b1;
            o_local_bus_grant_n <= 1'b1;
            o_dsp_ready_out_n <= 1'b1;
            o_shared_sram_strobe_n <= 1'b1;
            o_slave_ack_low_n <= 1'b1;
            o_slave_ack_high_n <= 1'b1;
        end else begin
            bc_r <= bc_nxt;
            sl_r <= sl_nxt;
            // One-hot output decode from the next state keeps each
            // output a flop with no glitches toward the DSP. [RQ13]
            o_global_bus_enable_n <= (bc_nxt == `DVG_BC_SOFF) ||
                (bc_nxt == `DVG_BC_SMOE) || (bc_nxt == `DVG_BC_SSOE) ||
                (bc_nxt == `DVG_BC_SGNT); // [RQ18]
            o_master_oe_n <= (bc_nxt == `DVG_BC_SMOE) ||
                (bc_nxt == `DVG_BC_SSOE) ||
                (bc_nxt == `DVG_BC_SGNT); // [RQ15] [RQ18]
            o_slave_oe_n <= !((bc_nxt == `DVG_BC_SSOE) ||
                (bc_nxt == `DVG_BC_SGNT));
            o_local_bus_grant_n <= !(bc_nxt == `DVG_BC_SGNT);
            // Used alone as external ready; high outside the ready cycle.
            o_dsp_ready_out_n <= !(bc_nxt == `DVG_BC_MRDY); // [RQ16] [RQ17]
            o_function_code <= `DVG_FC_SUPDATA; // [RQ20]
            o_shared_sram_strobe_n <= !((sl_nxt == `DVG_SL_STRB) ||
                (sl_nxt == `DVG_SL_ACK)); // [RQ21]
            if (sl_nxt == `DVG_SL_STRB) begin
                o_shared_sram_read_write <= i_slave_rd;
            end
            o_slave_ack_low_n <= !((sl_nxt == `DVG_SL_ACK) ||
                (sl_nxt == `DVG_SL_WAIT)); // [RQ21]
            o_slave_ack_high_n <= !((sl_nxt == `DVG_SL_ACK) ||
                (sl_nxt == `DVG_SL_WAIT));
        end
    end
endmodule
`default_nettype wire

/* verif/dvg_glue_assertions.sv */
// Port-level checks for the DSP to VME glue top.
`timescale 1ns/1ps
`default_nettype none
module dvg_glue_chk (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_power_up,
    input wire logic i_board_reset_n,
    input wire logic [3:0] i_status,
    input wire logic [2:0] i_segment_address_bits,
    input wire logic i_dsp_strobe_one_n,
    input wire logic i_local_bus_request_n,
    input wire logic i_data_size_ack_low_n,
    input wire logic i_data_size_ack_high_n,
    input wire logic i_local_bus_error_n,
    input wire logic [1:0] i_slave_size,
    input wire logic i_slave_strobe_n,
    input wire logic o_interrupt_reset_n,
    input wire logic o_priority_level_zero_line_n,
    input wire logic o_master_rd_n,
    input wire logic o_master_wr_n,
    input wire logic o_reg_rd_n,
    input wire logic o_reg_wr_n,
    input wire logic o_eprom_rd_n,
    input wire logic o_global_bus_enable_n,
    input wire logic o_master_oe_n,
    input wire logic o_slave_oe_n,
    input wire logic o_local_bus_grant_n,
    input wire logic o_dsp_ready_out_n,
    input wire logic o_shared_sram_strobe_n,
    input wire logic o_slave_ack_low_n,
    input wire logic o_slave_ack_high_n
);
    logic rd, wr, ok, ack_ok, slv_ok;
    logic [2:0] sg;
    logic [4:0] sel_exp;
    assign sg = i_segment_address_bits;
    assign rd = i_status[3:2] == 2'h2;
    assign wr = i_status == 4'hd || i_status == 4'he;
    assign ok = i_resetn && i_board_reset_n && !i_dsp_strobe_one_n;
    assign sel_exp = ~({5{ok}} & {rd && sg == 3'h4, wr && sg == 3'h7,
        rd && sg == 3'h7, wr && sg == 3'h5, rd && sg == 3'h5});
    assign ack_ok = !(i_data_size_ack_low_n || i_data_size_ack_high_n)
        || !i_local_bus_error_n;
    assign slv_ok = !o_local_bus_grant_n && !i_slave_strobe_n
        && i_slave_size == 2'h0;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    chk_irst_start: assert property ($rose(i_power_up) |=>
        !o_interrupt_reset_n) else $error("interrupt reset late");
    chk_pl0_answer: assert property (
        $fell(o_priority_level_zero_line_n) |-> !$past(i_board_reset_n))
        else $error("priority low early");
    chk_pl0_two: assert property ($fell(o_priority_level_zero_line_n)
        && i_power_up |-> !o_priority_level_zero_line_n[*2]
        ##1 o_priority_level_zero_line_n) else $error("priority width");
    chk_release_order: assert property (
        $rose(o_priority_level_zero_line_n) && !o_interrupt_reset_n
        |=> o_interrupt_reset_n) else $error("release order");
    // Each select is the decode of the inputs seen one edge earlier.
    chk_sel_decode: assert property (1'b1 |=>
        {o_eprom_rd_n, o_reg_wr_n, o_reg_rd_n, o_master_wr_n,
        o_master_rd_n} == $past(sel_exp)) else $error("select decode");
    chk_ready_cause: assert property ($fell(o_dsp_ready_out_n) |->
        $past(ack_ok) ##1 o_dsp_ready_out_n) else $error("ready misuse");
    chk_slave_order: assert property ($rose(o_global_bus_enable_n) |->
        !o_master_oe_n ##1 o_master_oe_n ##1 !o_slave_oe_n
        ##1 !o_local_bus_grant_n) else $error("slave handover order");
    chk_slave_end: assert property (!o_local_bus_grant_n &&
        i_local_bus_request_n |=> o_local_bus_grant_n && o_slave_oe_n
        && !o_global_bus_enable_n) else $error("slave end");
    chk_sram_ack: assert property ($fell(o_shared_sram_strobe_n) |->
        $past(slv_ok) ##1 !o_shared_sram_strobe_n && !o_slave_ack_low_n
        && !o_slave_ack_high_n) else $error("slave ack");
endmodule
bind dvg_glue dvg_glue_chk dvg_glue_chk_inst (.i_clk, .i_resetn,
    .i_power_up, .i_board_reset_n, .i_status, .i_segment_address_bits,
    .i_dsp_strobe_one_n, .i_local_bus_request_n, .i_data_size_ack_low_n,
    .i_data_size_ack_high_n, .i_local_bus_error_n, .i_slave_size,
    .i_slave_strobe_n, .o_interrupt_reset_n, .o_priority_level_zero_line_n,
    .o_master_rd_n, .o_master_wr_n, .o_reg_rd_n, .o_reg_wr_n,
    .o_eprom_rd_n, .o_global_bus_enable_n, .o_master_oe_n, .o_slave_oe_n,
    .o_local_bus_grant_n, .o_dsp_ready_out_n, .o_shared_sram_strobe_n,
    .o_slave_ack_low_n, .o_slave_ack_high_n);
`default_nettype wire

/* verif/dvg_bus_ctrl_model.sv */
// Behavioural bus-controller chip: reset answer and master acknowledges.
`timescale 1ns/1ps
`default_nettype none
module dvg_bus_ctrl_model #(parameter int HOLD = 8) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_interrupt_reset_n,
    input wire logic i_sel_n,
    input wire logic i_ready_n,
    input wire logic i_err,
    input wire logic [3:0] i_wait,
    output logic o_board_reset_n,
    output logic o_ack_low_n,
    output logic o_ack_high_n,
    output logic o_bus_error_n
);
    // The system reset stretch is scaled down to HOLD clocks.
    int hold;
    logic pend;
    logic [3:0] cnt;
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_board_reset_n <= 1'b1;
            hold <= 0;
        end else if (!i_interrupt_reset_n) begin
            o_board_reset_n <= 1'b0;
            hold <= HOLD;
        end else if (hold != 0) begin
            hold <= hold - 1;
        end else begin
            o_board_reset_n <= 1'b1;
        end
    end
    // Acks are pulled up lines, so they return high once released.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn || !i_ready_n) begin
            pend <= 1'b0;
            {o_ack_low_n, o_ack_high_n, o_bus_error_n} <= 3'h7;
        end else if (!i_sel_n && !pend) begin
            pend <= 1'b1;
            cnt <= i_wait;
        end else if (pend && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (pend) begin
            {o_ack_low_n, o_ack_high_n} <= {2{i_err}};
            o_bus_error_n <= !i_err;
        end
    end
endmodule
`default_nettype wire

/* verif/dvg_glue_tb_top.sv */
// Self-checking bench for the DSP to VME glue top.
`timescale 1ns/1ps
`default_nettype none
module dvg_glue_tb_top;
    logic i_clk = 1'b0, i_resetn = 1'b0, i_power_up = 1'b0, err = 1'b0;
    logic stb_n = 1'b1, lbr_n = 1'b1, s_rd = 1'b1, s_stb_n = 1'b1;
    logic [3:0] i_status = 4'h0, ack_wait = 4'h0;
    logic [2:0] seg = 3'h0;
    logic [1:0] s_size = 2'h0;
    wire logic brst_n, ackl_n, ackh_n, berr_n, irst_n, pl0_n, mrd_n, mwr_n;
    wire logic rrd_n, rwr_n, prom_n, gbe_n, moe_n, soe_n, gnt_n, rdy_n;
    wire logic sstb_n, srw, sackl_n, sackh_n;
    wire logic [2:0] fc;
    int failures = 0, samples_checked = 0, n, k;
    always #25 i_clk = ~i_clk;
    dvg_bus_ctrl_model dvg_bus_ctrl_model_inst (.i_clk(i_clk),
        .i_resetn(i_resetn), .i_interrupt_reset_n(irst_n),
        .i_sel_n(mrd_n & mwr_n & rrd_n & rwr_n), .i_ready_n(rdy_n),
        .i_err(err), .i_wait(ack_wait), .o_board_reset_n(brst_n),
        .o_ack_low_n(ackl_n), .o_ack_high_n(ackh_n), .o_bus_error_n(berr_n));
    dvg_glue dvg_glue_inst (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_power_up(i_power_up), .i_board_reset_n(brst_n),
        .i_status(i_status), .i_segment_address_bits(seg),
        .i_dsp_strobe_one_n(stb_n), .i_local_bus_request_n(lbr_n),
        .i_data_size_ack_low_n(ackl_n), .i_data_size_ack_high_n(ackh_n),
        .i_local_bus_error_n(berr_n), .i_slave_size(s_size),
        .i_slave_rd(s_rd), .i_slave_strobe_n(s_stb_n),
        .o_interrupt_reset_n(irst_n), .o_priority_level_zero_line_n(pl0_n),
        .o_master_rd_n(mrd_n), .o_master_wr_n(mwr_n), .o_reg_rd_n(rrd_n),
        .o_reg_wr_n(rwr_n), .o_eprom_rd_n(prom_n),
        .o_global_bus_enable_n(gbe_n), .o_master_oe_n(moe_n),
        .o_slave_oe_n(soe_n), .o_local_bus_grant_n(gnt_n),
        .o_dsp_ready_out_n(rdy_n), .o_function_code(fc),
        .o_shared_sram_strobe_n(sstb_n), .o_shared_sram_read_write(srw),
        .o_slave_ack_low_n(sackl_n), .o_slave_ack_high_n(sackh_n));
    task automatic step();
        @(posedge i_clk);
        #5;
    endtask
    task automatic end_sim();
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bound(input int m);
        if (m >= 40) begin
            failures++;
            end_sim();
        end
    endtask
    task automatic t_power(input logic abort);
        logic prev;
        i_power_up = 1'b1;
        step();
        chk(irst_n, 1'b0);
        if (abort) begin
            i_power_up = 1'b0;
            step();
            chk({irst_n, pl0_n}, 2'h3);
            repeat (20) step();
        end else begin
            k = 0;
            prev = 1'b1;
            for (n = 0; n < 40 && irst_n !== 1'b1; n++) begin
                if (pl0_n === 1'b0) k++;
                if (brst_n === 1'b1) chk(pl0_n, 1'b1);
                prev = pl0_n;
                step();
            end
            bound(n);
            chk(k[7:0], 8'h2);
            chk({prev, pl0_n}, 2'h3);
            repeat (5) step();
            chk({irst_n, pl0_n}, 2'h3);
            // Board reset is still low here; bus control must sit idle.
            chk({gbe_n, moe_n, soe_n, gnt_n, rdy_n}, 5'h07);
            for (n = 0; n < 40 && brst_n !== 1'b1; n++) step();
            bound(n);
        end
    endtask
    task automatic t_decode();
        logic [4:0] e;
        logic r, w;
        for (k = 0; k < 256; k++) begin
            {stb_n, i_status, seg} = k[7:0];
            step();
            r = i_status[3:2] == 2'h2;
            w = i_status == 4'hd || i_status == 4'he;
            e = {r & seg == 3'h4, w & seg == 3'h7, r & seg == 3'h7,
                w & seg == 3'h5, r & seg == 3'h5};
            e = stb_n ? 5'h1f : ~e;
            chk({prom_n, rwr_n, rrd_n, mwr_n, mrd_n}, e);
        end
        repeat (10) step();
    endtask
    task automatic t_master(input logic [3:0] st, input logic [2:0] sg,
        input logic [3:0] w, input logic e);
        {i_status, seg, stb_n, ack_wait, err} = {st, sg, 1'b0, w, e};
        step();
        stb_n = 1'b1;
        for (n = 0; n < 40 && rdy_n !== 1'b0; n++) begin
            chk({gbe_n, moe_n, fc}, 5'h5);
            step();
        end
        bound(n);
        chk(n > w, 1'b1);
        step();
        chk(rdy_n, 1'b1);
        repeat (3) step();
    endtask
    task automatic t_slave(input logic [1:0] sz, input logic rd);
        lbr_n = 1'b0;
        for (n = 0; n < 40 && gnt_n !== 1'b0; n++) step();
        bound(n);
        chk({gbe_n, moe_n, soe_n}, 3'h6);
        {s_size, s_stb_n, s_rd} = {sz, 1'b0, rd};
        for (n = 0; n < 10 && sackl_n !== 1'b0; n++) step();
        chk(n < 10, sz == 2'h0);
        if (n < 10) chk({sstb_n, srw, sackh_n}, {1'b0, rd, 1'b0});
        {s_stb_n, lbr_n} = 2'h3;
        repeat (2) step();
        chk({gnt_n, soe_n, gbe_n}, 3'h6);
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        #5;
        chk({mrd_n, mwr_n, rrd_n, rwr_n, prom_n, gbe_n, moe_n, soe_n,
            gnt_n, rdy_n}, 10'h3e7);
        i_resetn = 1'b1;
        step();
        t_power(1'b1);
        t_power(1'b0);
        t_decode();
        t_master(4'h8, 3'h5, 4'h0, 1'b0);
        t_master(4'hd, 3'h5, 4'h5, 1'b0);
        t_master(4'he, 3'h7, 4'h0, 1'b1);
        t_master(4'hb, 3'h7, 4'h2, 1'b0);
        t_slave(2'h0, 1'b1);
        t_slave(2'h0, 1'b0);
        t_slave(2'h2, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
